// ==== rtl/modstat_pkg.sv ====
// Package of constants and carrier types for the module status and event block.
package modstat_pkg;

    // -------------------------------------------------------------------------
    // Register layout
    // -------------------------------------------------------------------------
    localparam int REG_W = 32;
    localparam int BIT_FAST_DOWN   = 16;
    localparam int BIT_RATE_LIMIT  = 21;
    localparam int BIT_KILL        = 15;
    localparam int BIT_TEMP_OK     = 14;
    localparam int BIT_SUPPLY_OK   = 13;
    localparam int BIT_MODULE_OK   = 12;
    localparam int BIT_EVT_PENDING = 11;
    localparam int BIT_INTERLOCK   = 10;
    localparam int BIT_STABLE      = 9;
    localparam int BIT_NO_FAULT    = 8;
    localparam int BIT_BAD_SET     = 6;
    localparam int BIT_HW_FAULT    = 4;
    localparam int BIT_LIVE        = 3;
    localparam int BIT_FINE        = 0;
    localparam logic [REG_W-1:0] EVT_TEMP_MASK      = 32'h0000_4000;
    localparam logic [REG_W-1:0] EVT_SUPPLY_MASK    = 32'h0000_2000;
    localparam logic [REG_W-1:0] EVT_INTERLOCK_MASK = 32'h0000_0400;
    localparam logic [REG_W-1:0] EVT_BAD_SET_MASK   = 32'h0000_0040;
    localparam logic [REG_W-1:0] EVT_HW_FAULT_MASK  = 32'h0000_0010;
    localparam logic [REG_W-1:0] EVT_IMPL_MASK      = 32'h0000_6450;
    localparam logic [REG_W-1:0] EVT_BLOCKING_MASK  = 32'h0000_6410;
    localparam logic [REG_W-1:0] REG_ZERO           = 32'h0000_0000;

    // -------------------------------------------------------------------------
    // Supply windows in millivolts, live threshold in volts
    // -------------------------------------------------------------------------
    localparam int V24_MIN_MV = 21600;
    localparam int V24_MAX_MV = 26400;
    localparam int V5_MIN_MV  = 4750;
    localparam int V5_MAX_MV  = 5250;
    localparam int LIVE_THRESHOLD_V = 60;
    localparam int MV_W = 16;

    // Per-channel condition bundle, one per channel.
    typedef struct packed {
        logic v_limit;
        logic i_limit;
        logic i_trip;
        logic ext_inhibit;
        logic v_bounds;
        logic i_bounds;
        logic arc_error;
        logic generating;
        logic ramping;
        logic above_threshold;
    } chan_cond_t;

    // Module supervisory inputs, all asynchronous to clk.
    typedef struct packed {
        logic temp_ok;
        logic interlock_closed;
        logic hw_failure;
        logic power_fail;
        logic delayed_trip;
    } superv_t;

    // Commands from the host command interpreter.
    typedef struct packed {
        logic            evt_wr;
        logic [REG_W-1:0] evt_wdata;
        logic            chan_clear;
        logic            clear_all;
        logic            set_reject;
        logic            set_ok;
    } host_cmd_t;

    // Shutdown requests to the channel sequencers.
    typedef struct packed {
        logic ramp_off;
        logic hard_off;
        logic fast_down;
        logic hv_inhibit;
        logic perm_inhibit;
    } shutdown_t;

endpackage

// ==== rtl/module_status_event_logic.sv ====
// Module condition flags, module event latches and high-voltage blocking.
`timescale 1ns/1ps
`default_nettype none
module module_status_event_logic
    import modstat_pkg::*;
#(
    parameter int NCH = 32
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  var  chan_cond_t [NCH-1:0] chan_cond,
    input  wire logic [NCH-1:0]       chan_evt_summary,
    input  wire logic [NCH-1:0]       chan_evt_mask,
    input  var  superv_t              superv,
    input  wire logic [MV_W-1:0]      v24_mv,
    input  wire logic [MV_W-1:0]      v5_mv,
    input  wire logic                 kill_enable,
    input  wire logic                 fine_adjust,
    input  wire logic                 rate_limit_disable,
    input  wire logic [REG_W-1:0]     evt_mask,
    input  var  host_cmd_t            cmd,
    input  wire logic                 hv_on_req,
    input  wire logic                 vset_increase_req,
    output var  logic [REG_W-1:0]     module_condition_status,
    output var  logic [REG_W-1:0]     module_event_latch,
    output var  logic                 chan_event_clear,
    output var  logic                 hv_on_grant,
    output var  logic                 vset_increase_grant,
    output var  logic                 blocking,
    output var  shutdown_t            shutdown
);

    // -------------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------------
    // Channels beyond the register width would be lost silently.
    if (NCH < 1 || NCH > REG_W) begin : g_nch_chk
        $error("NCH out of range.");
    end
    // Every flag position must fall inside the register.
    if (BIT_RATE_LIMIT >= REG_W) begin : g_bit_chk
        $error("Flag outside register.");
    end
    // Blocking events must all be implemented events.
    if ((EVT_BLOCKING_MASK & ~EVT_IMPL_MASK) != REG_ZERO) begin : g_blk_chk
        $error("Blocking event not implemented.");
    end
    // Supply limits must fit the measurement width.
    if (V24_MAX_MV >= 2**MV_W || V5_MAX_MV >= 2**MV_W) begin : g_mv_chk
        $error("Supply limit too wide.");
    end

    // -------------------------------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------------------------------
    localparam int SUP_W = $bits(superv_t);
    localparam int CH_W  = $bits(chan_cond_t);
    superv_t                sup_s;
    chan_cond_t [NCH-1:0]   cond_s;
    logic [SUP_W-1:0]       sup_q;
    logic [NCH*CH_W-1:0]    cond_q;

    // Supervisory pins come straight from the analog side.
    sync2 #(.W(SUP_W)) u_sup_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (superv),
        .q     (sup_q)
    );

    // Channel conditions come from channel controllers on other timing.
    sync2 #(.W(NCH*CH_W)) u_chan_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (chan_cond),
        .q     (cond_q)
    );

    assign sup_s  = superv_t'(sup_q);
    assign cond_s = cond_q;

    // -------------------------------------------------------------------------
    // Live condition derivation
    // -------------------------------------------------------------------------
    logic [NCH-1:0] chan_fault;
    logic [NCH-1:0] chan_live;
    logic [NCH-1:0] chan_ramp;

    // Per-channel reductions; each channel contributes one bit.
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            assign chan_fault[g] = cond_s[g].v_limit | cond_s[g].i_limit |
                                   cond_s[g].i_trip | cond_s[g].ext_inhibit |
                                   cond_s[g].v_bounds | cond_s[g].i_bounds |
                                   cond_s[g].arc_error;
            assign chan_live[g]  = cond_s[g].generating |
                                   cond_s[g].above_threshold;
            assign chan_ramp[g]  = cond_s[g].ramping;
        end
    endgenerate

    // Window test shared by both supply rails.
    function automatic logic in_window(input logic [MV_W-1:0] v,
                                       input logic [MV_W-1:0] lo,
                                       input logic [MV_W-1:0] hi);
        in_window = (v >= lo) && (v <= hi);
    endfunction

    logic [MV_W-1:0] v24_meta_reg;
    logic [MV_W-1:0] v5_meta_reg;
    logic [MV_W-1:0] v24_reg;
    logic [MV_W-1:0] v5_reg;
    logic            supplies_ok_flag;
    logic            no_channel_fault_flag;
    logic            output_live_flag;
    logic            all_stable_flag;
    logic            event_pending_flag;
    logic            ramp_rate_limited_flag;

    // Measurements pass two flops like any pin. A word is trusted only
    // because the converter holds it steady well beyond two cycles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            v24_meta_reg <= '0;
            v5_meta_reg  <= '0;
            v24_reg      <= '0;
            v5_reg       <= '0;
        end else begin
            v24_meta_reg <= v24_mv;
            v5_meta_reg  <= v5_mv;
            v24_reg      <= v24_meta_reg;
            v5_reg       <= v5_meta_reg;
        end
    end

    // Module flags are reductions read by the status word; only supplies_ok_flag also feeds the latches.
    assign supplies_ok_flag =
        in_window(v24_reg, MV_W'(V24_MIN_MV), MV_W'(V24_MAX_MV)) &&
        in_window(v5_reg, MV_W'(V5_MIN_MV), MV_W'(V5_MAX_MV));
    assign no_channel_fault_flag  = ~|chan_fault;
    assign output_live_flag       = |chan_live;
    assign all_stable_flag        = ~|chan_ramp;
    assign event_pending_flag     = |(chan_evt_summary & chan_evt_mask);
    assign ramp_rate_limited_flag = (kill_enable | sup_s.delayed_trip) &
                                    ~rate_limit_disable;

    // -------------------------------------------------------------------------
    // Input error and service state
    // -------------------------------------------------------------------------
    logic bad_setpoint_reg;
    logic hw_fault_reg;

    // A rejected set value sets the flag; the next good set clears it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bad_setpoint_reg <= 1'b0;
        end else if (cmd.set_reject) begin
            bad_setpoint_reg <= 1'b1;
        end else if (cmd.set_ok) begin
            bad_setpoint_reg <= 1'b0;
        end
    end

    // Service is sticky until reset: a failed module must not be revived.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hw_fault_reg <= 1'b0;
        end else if (sup_s.hw_failure) begin
            hw_fault_reg <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Event latches
    // -------------------------------------------------------------------------
    logic [REG_W-1:0] evt_reg;
    logic [REG_W-1:0] evt_next;
    logic [REG_W-1:0] evt_cond;
    logic [REG_W-1:0] evt_clr;
    logic             module_ok_flag;

    // Conditions that raise each event; level high covers a rising edge too,
    // since the flag is sampled every cycle.
    always_comb begin
        evt_cond = REG_ZERO;
        evt_cond[BIT_TEMP_OK]   = ~sup_s.temp_ok;
        evt_cond[BIT_SUPPLY_OK] = ~supplies_ok_flag;
        evt_cond[BIT_INTERLOCK] = ~sup_s.interlock_closed;
        evt_cond[BIT_BAD_SET]   = bad_setpoint_reg | cmd.set_reject;
        evt_cond[BIT_HW_FAULT]  = hw_fault_reg | sup_s.hw_failure;
    end

    // Clear mask: one-bits of a host write, or everything on clear-all.
    always_comb begin
        evt_clr = REG_ZERO;
        if (cmd.evt_wr) begin
            evt_clr = cmd.evt_wdata;
        end
        if (cmd.clear_all) begin
            evt_clr = EVT_IMPL_MASK;
        end
    end

    // Set wins over clear so an event in the clear cycle is kept.
    assign evt_next = ((evt_reg & ~evt_clr) | evt_cond) & EVT_IMPL_MASK;

    // Latch state; only reset or a host clear removes a bit.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_reg <= REG_ZERO;
        end else begin
            evt_reg <= evt_next;
        end
    end

    // Module good reads the temperature, supply and interlock latches, so a past fault of those counts until cleared.
    assign module_ok_flag = no_channel_fault_flag &
                            ~|(evt_reg & (EVT_TEMP_MASK | EVT_SUPPLY_MASK |
                                          EVT_INTERLOCK_MASK));

    // -------------------------------------------------------------------------
    // Blocking
    // -------------------------------------------------------------------------
    logic block_now;

    // Input error is absent from the blocking set, so it never blocks; the
    // term is combinational so a cleared latch or mask frees at once.
    assign block_now = |(evt_reg & evt_mask & EVT_BLOCKING_MASK);

    // Grants are registered answers to the one-cycle requests.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hv_on_grant         <= 1'b0;
            vset_increase_grant <= 1'b0;
            blocking            <= 1'b0;
        end else begin
            hv_on_grant         <= hv_on_req & ~block_now & ~hw_fault_reg &
                                   ~sup_s.hw_failure;
            vset_increase_grant <= vset_increase_req &
                                   ~(block_now & output_live_flag);
            blocking            <= block_now;
        end
    end

    // -------------------------------------------------------------------------
    // Shutdown requests and channel clear
    // -------------------------------------------------------------------------
    // The raw fault pin joins the sticky flag so the cut comes one cycle
    // earlier; the sequencers must treat these as levels, not pulses.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutdown         <= '0;
            chan_event_clear <= 1'b0;
        end else begin
            shutdown.ramp_off     <= ~sup_s.temp_ok;
            shutdown.hard_off     <= ~sup_s.interlock_closed |
                                     sup_s.hw_failure | hw_fault_reg;
            shutdown.fast_down    <= sup_s.power_fail;
            shutdown.hv_inhibit   <= block_now;
            shutdown.perm_inhibit <= hw_fault_reg | sup_s.hw_failure;
            chan_event_clear      <= cmd.chan_clear | cmd.clear_all;
        end
    end

    // -------------------------------------------------------------------------
    // Readable registers
    // -------------------------------------------------------------------------
    logic [REG_W-1:0] cond_next;

    // Reserved bits stay zero.
    always_comb begin
        cond_next = REG_ZERO;
        cond_next[BIT_RATE_LIMIT]  = ramp_rate_limited_flag;
        cond_next[BIT_FAST_DOWN]   = sup_s.power_fail;
        cond_next[BIT_KILL]        = kill_enable;
        cond_next[BIT_TEMP_OK]     = sup_s.temp_ok;
        cond_next[BIT_SUPPLY_OK]   = supplies_ok_flag;
        cond_next[BIT_MODULE_OK]   = module_ok_flag;
        cond_next[BIT_EVT_PENDING] = event_pending_flag;
        cond_next[BIT_INTERLOCK]   = sup_s.interlock_closed;
        cond_next[BIT_STABLE]      = all_stable_flag;
        cond_next[BIT_NO_FAULT]    = no_channel_fault_flag;
        cond_next[BIT_BAD_SET]     = bad_setpoint_reg;
        cond_next[BIT_HW_FAULT]    = hw_fault_reg;
        cond_next[BIT_LIVE]        = output_live_flag;
        cond_next[BIT_FINE]        = fine_adjust;
    end

    // Both words are registered so the host never reads a glitching flag;
    // the latch word is loaded from evt_next, so it lags the live flags no more than the status word.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            module_condition_status <= REG_ZERO;
            module_event_latch      <= REG_ZERO;
        end else begin
            module_condition_status <= cond_next;
            module_event_latch      <= evt_next;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/sync2.sv ====
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // Only the second stage is visible to logic.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
// Behavioural host that issues register writes, clear commands and requests.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import modstat_pkg::*;
(
    input  wire logic      clk,
    output var  host_cmd_t cmd,
    output var  logic      hv_on_req,
    output var  logic      vset_increase_req
);
    initial begin
        cmd = '0;
        hv_on_req = 1'b0;
        vset_increase_req = 1'b0;
    end

    // Holds one command for exactly one taking edge, then returns just after that edge.
    task automatic issue(input int kind, input logic [REG_W-1:0] data);
        @(posedge clk);
        cmd.evt_wdata <= data;
        case (kind)
            0: cmd.evt_wr <= 1'b1;
            1: cmd.chan_clear <= 1'b1;
            2: cmd.clear_all <= 1'b1;
            3: cmd.set_reject <= 1'b1;
            4: cmd.set_ok <= 1'b1;
            5: hv_on_req <= 1'b1;
            default: vset_increase_req <= 1'b1;
        endcase
        @(posedge clk);
        cmd <= '0;
        hv_on_req <= 1'b0;
        vset_increase_req <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// ==== test/modstat_asserts.sv ====
// Concurrent checks on the ports of the module status and event block.
`timescale 1ns/1ps
`default_nettype none
module modstat_asserts
    import modstat_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic [REG_W-1:0] evt_mask,
    input var  host_cmd_t        cmd,
    input wire logic             hv_on_req,
    input wire logic             vset_increase_req,
    input wire logic [REG_W-1:0] module_condition_status,
    input wire logic [REG_W-1:0] module_event_latch,
    input wire logic             chan_event_clear,
    input wire logic             hv_on_grant,
    input wire logic             vset_increase_grant,
    input wire logic             blocking
);
    // Every condition bit that has a meaning; all others must stay low.
    localparam logic [REG_W-1:0] COND_USED = 32'h0021_FF59;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    evt_reserved_a: assert property ((module_event_latch & ~EVT_IMPL_MASK) == REG_ZERO)
        else $error("reserved event bit set");
    cond_reserved_a: assert property ((module_condition_status & ~COND_USED) == REG_ZERO)
        else $error("reserved condition bit set");
    // The first edge after reset still sees pre-reset values, so the past reset is required.
    latch_hold_a: assert property ($past(rst_n) && !$past(cmd.evt_wr) && !$past(cmd.clear_all)
        |-> ($past(module_event_latch) & ~module_event_latch) == REG_ZERO)
        else $error("event latch cleared itself");
    zero_write_a: assert property ($past(rst_n) && $past(cmd.evt_wr) && !$past(cmd.clear_all)
        |-> ($past(module_event_latch) & ~$past(cmd.evt_wdata) & ~module_event_latch) == REG_ZERO)
        else $error("zero write cleared a latch");
    clear_pulse_a: assert property ($past(rst_n)
        |-> chan_event_clear == ($past(cmd.chan_clear) || $past(cmd.clear_all)))
        else $error("channel clear pulse wrong");
    hv_block_a: assert property (hv_on_req && (module_event_latch & evt_mask & EVT_BLOCKING_MASK) != REG_ZERO |=> !hv_on_grant)
        else $error("switch on granted while blocked");
    // The status word one cycle on shows the live flag that the grant decision used.
    vset_block_a: assert property (vset_increase_req
        && (module_event_latch & evt_mask & EVT_BLOCKING_MASK) != REG_ZERO
        |=> !(module_condition_status[BIT_LIVE] && vset_increase_grant))
        else $error("increase granted while blocked");
    hv_cause_a: assert property (!hv_on_req |=> !hv_on_grant)
        else $error("switch on grant without request");
    vset_cause_a: assert property (!vset_increase_req |=> !vset_increase_grant)
        else $error("increase grant without request");
    bad_set_a: assert property (cmd.set_reject ##1 !cmd.set_ok |-> ##1 module_condition_status[BIT_BAD_SET])
        else $error("input error flag missing");

    cover property (hv_on_req ##1 hv_on_grant);
    cover property (blocking && hv_on_req);
    cover property (chan_event_clear);
endmodule
`default_nettype wire

// ==== test/module_status_event_logic_tb.sv ====
// Self-checking bench for the module status and event block.
`timescale 1ns/1ps
`default_nettype none
module module_status_event_logic_tb;
    import modstat_pkg::*;
    localparam int NCH = 4;
    // Good supplies, closed interlock, good temperature, nothing ramping.
    localparam logic [31:0] IDLE = 32'h0000_7700;
    logic clk, rst_n, kill_enable, fine_adjust, rate_limit_disable;
    logic hv_on_req, vset_increase_req, chan_event_clear, hv_on_grant, vset_increase_grant, blocking;
    chan_cond_t [NCH-1:0] chan_cond;
    logic [NCH-1:0] chan_evt_summary, chan_evt_mask;
    superv_t superv;
    logic [MV_W-1:0] v24_mv, v5_mv;
    logic [REG_W-1:0] evt_mask, module_condition_status, module_event_latch;
    host_cmd_t cmd;
    shutdown_t shutdown;
    int num_errors, n_checks, cycles;

    module_status_event_logic #(.NCH(NCH)) dut_u (.clk(clk), .rst_n(rst_n),
        .chan_cond(chan_cond), .chan_evt_summary(chan_evt_summary), .chan_evt_mask(chan_evt_mask),
        .superv(superv), .v24_mv(v24_mv), .v5_mv(v5_mv), .kill_enable(kill_enable),
        .fine_adjust(fine_adjust), .rate_limit_disable(rate_limit_disable), .evt_mask(evt_mask),
        .cmd(cmd), .hv_on_req(hv_on_req), .vset_increase_req(vset_increase_req),
        .module_condition_status(module_condition_status), .module_event_latch(module_event_latch),
        .chan_event_clear(chan_event_clear), .hv_on_grant(hv_on_grant),
        .vset_increase_grant(vset_increase_grant), .blocking(blocking), .shutdown(shutdown));
    host_model host_u (.clk(clk), .cmd(cmd), .hv_on_req(hv_on_req),
        .vset_increase_req(vset_increase_req));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pins pass two sync flops and a register, so five edges covers the lag.
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    // Restores quiet inputs and wipes every latch; a still-active condition would show here.
    task automatic fix();
        @(posedge clk);
        chan_cond <= '0;
        chan_evt_summary <= '0;
        superv <= 5'h18;
        v24_mv <= 16'h5DC0;
        v5_mv <= 16'h1388;
        {kill_enable, fine_adjust, rate_limit_disable} <= 3'h0;
        settle();
        host_u.issue(0, EVT_IMPL_MASK);
        settle();
        chk(module_event_latch, REG_ZERO);
        chk(module_condition_status, IDLE);
    endtask

    task automatic s_cond();
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            chan_cond[2] <= chan_cond_t'(10'h001 << i);
            settle();
            chk(module_condition_status, (i == 0 || i == 2) ? 32'h7708 : (i == 1) ? 32'h7500 : 32'h6600);
        end
        @(posedge clk);
        chan_cond[2] <= '0;
        chan_evt_summary <= 4'h4;
        chan_evt_mask <= 4'hB;
        settle();
        chk(module_condition_status, IDLE);
        @(posedge clk);
        chan_evt_mask <= 4'h4;
        settle();
        chk(module_condition_status, IDLE | 32'h0000_0800);
        fix();
    endtask

    task automatic s_ctrl();
        @(posedge clk);
        kill_enable <= 1'b1;
        settle();
        chk(module_condition_status, IDLE | 32'h0020_8000);
        @(posedge clk);
        rate_limit_disable <= 1'b1;
        settle();
        chk(module_condition_status, IDLE | 32'h0000_8000);
        @(posedge clk);
        {kill_enable, rate_limit_disable, fine_adjust} <= 3'h1;
        superv.delayed_trip <= 1'b1;
        settle();
        chk(module_condition_status, IDLE | 32'h0020_0001);
        @(posedge clk);
        superv.delayed_trip <= 1'b0;
        superv.power_fail <= 1'b1;
        settle();
        chk(module_condition_status, IDLE | 32'h0001_0001);
        chk(32'(shutdown.fast_down), 32'h0000_0001);
        fix();
    endtask

    // Window edges of both rails; the latch keeps supply-bad once seen.
    task automatic s_supply();
        logic [15:0] t[8] = '{16'h545F, 16'h5460, 16'h6720, 16'h6721,
                              16'h128D, 16'h128E, 16'h1482, 16'h1483};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            v24_mv <= (i < 4) ? t[i] : 16'h5DC0;
            v5_mv <= (i < 4) ? 16'h1388 : t[i];
            settle();
            chk(module_condition_status, (i % 4 == 0 || i % 4 == 3) ? 32'h4700 : 32'h6700);
            chk(module_event_latch, EVT_SUPPLY_MASK);
        end
        fix();
    endtask

    task automatic s_block();
        @(posedge clk);
        evt_mask <= EVT_IMPL_MASK;
        superv.interlock_closed <= 1'b0;
        settle();
        chk(32'(shutdown.hard_off), 32'h0000_0001);
        chk(module_event_latch, EVT_INTERLOCK_MASK);
        @(posedge clk);
        superv.interlock_closed <= 1'b1;
        chan_cond[0].generating <= 1'b1;
        settle();
        host_u.issue(0, ~EVT_INTERLOCK_MASK);
        chk(module_event_latch, EVT_INTERLOCK_MASK);
        chk(32'(blocking), 32'h0000_0001);
        chk(32'(shutdown.hv_inhibit), 32'h0000_0001);
        host_u.issue(5, REG_ZERO);
        chk(32'(hv_on_grant), 32'h0000_0000);
        host_u.issue(6, REG_ZERO);
        chk(32'(vset_increase_grant), 32'h0000_0000);
        @(posedge clk);
        evt_mask <= EVT_IMPL_MASK & ~EVT_INTERLOCK_MASK;
        host_u.issue(5, REG_ZERO);
        chk(32'(hv_on_grant), 32'h0000_0001);
        chk(32'(blocking), 32'h0000_0000);
        @(posedge clk);
        evt_mask <= EVT_IMPL_MASK;
        host_u.issue(0, EVT_INTERLOCK_MASK);
        chk(module_event_latch, REG_ZERO);
        host_u.issue(6, REG_ZERO);
        chk(32'(vset_increase_grant), 32'h0000_0001);
        fix();
    endtask

    task automatic s_input();
        host_u.issue(3, REG_ZERO);
        settle();
        chk(module_condition_status, IDLE | 32'h0000_0040);
        chk(module_event_latch, EVT_BAD_SET_MASK);
        host_u.issue(5, REG_ZERO);
        chk(32'(hv_on_grant), 32'h0000_0001);
        host_u.issue(4, REG_ZERO);
        settle();
        chk(module_condition_status, IDLE);
        @(posedge clk);
        superv.temp_ok <= 1'b0;
        settle();
        chk(32'(shutdown.ramp_off), 32'h0000_0001);
        chk(module_event_latch, EVT_TEMP_MASK | EVT_BAD_SET_MASK);
        @(posedge clk);
        superv.temp_ok <= 1'b1;
        settle();
        host_u.issue(2, REG_ZERO);
        chk(32'(chan_event_clear), 32'h0000_0001);
        chk(module_event_latch, REG_ZERO);
        host_u.issue(1, REG_ZERO);
        chk(32'(chan_event_clear), 32'h0000_0001);
    endtask

    // Runs last: the fault stays until reset.
    task automatic s_hw();
        @(posedge clk);
        superv.hw_failure <= 1'b1;
        settle();
        chk(module_condition_status, IDLE | 32'h0000_0010);
        chk(module_event_latch, EVT_HW_FAULT_MASK);
        chk(32'(shutdown.perm_inhibit), 32'h0000_0001);
        @(posedge clk);
        superv.hw_failure <= 1'b0;
        evt_mask <= REG_ZERO;
        settle();
        host_u.issue(5, REG_ZERO);
        chk(32'(hv_on_grant), 32'h0000_0000);
    endtask

    initial begin
        rst_n = 1'b0;
        chan_cond = '0;
        chan_evt_summary = '0;
        chan_evt_mask = '0;
        superv = 5'h18;
        v24_mv = 16'h5DC0;
        v5_mv = 16'h1388;
        {kill_enable, fine_adjust, rate_limit_disable} = 3'h0;
        evt_mask = REG_ZERO;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        fix();
        s_cond();
        s_ctrl();
        s_supply();
        s_block();
        s_input();
        s_hw();
        complete_run();
    end
endmodule

bind module_status_event_logic modstat_asserts chk_u (.clk(clk), .rst_n(rst_n),
    .evt_mask(evt_mask), .cmd(cmd), .hv_on_req(hv_on_req),
    .vset_increase_req(vset_increase_req), .module_condition_status(module_condition_status),
    .module_event_latch(module_event_latch), .chan_event_clear(chan_event_clear),
    .hv_on_grant(hv_on_grant), .vset_increase_grant(vset_increase_grant), .blocking(blocking));
`default_nettype wire
